// file: design/low_power_timer_counter.sv
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps

// Contract
// - once enabled, counter starts at zero and counts up to the compare value
// - compare flag sets on the increment after count equals compare
// - each compare event gives one trigger pulse as well as the flag
// - interrupt asserted while flag set and interrupt enable on
// - disabling stops counting and forces the counter to zero
// - free-running counter passes compare without clearing, still flagging it, and wraps only on overflow
// - without free-running, counter clears when the flag sets
// - bypass picks the raw source clock (time mode) or raw pulse input (pulse mode), else the prescaler/filter output, as count clock
// - time mode prescale code n divides source by 2^(n+1)
// - pulse mode filter code n needs 2^n stable samples; code 0 unsupported
// - two-bit select picks one of four pulse inputs
// - polarity picks active-high or active-low pulse input
// - input select and polarity only matter in pulse mode
// - mode bit picks time counter or pulse counter
// - two-bit clock select picks one of four source clocks
// - dma enable lets the compare event raise a dma request
// - software reads the live counter value
module low_power_timer_counter
    import lptc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [3:0] src_clk_i,
    input wire logic [3:0] pulse_in_i,
    output logic irq_o,
    output logic trigger_o,
    output logic dma_req_o
);

    // ==========================================================
    // helpers

    // all-ones mask of k bits, saturating at 16
    function automatic logic [15:0] low_mask(input logic [4:0] k);
        logic [16:0] v;
        v = (17'h00001 << k) - 17'h00001;
        return v[15:0];
    endfunction : low_mask

    // merge write data into an old word by byte lane
    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_be

    function automatic logic [31:0] ctrl_image(input state_t st);
        logic [31:0] r;
        r = 32'h00000000;
        r[CTRL_ENABLE_BIT] = st.enable;
        r[CTRL_MODE_BIT] = (st.mode == MODE_PULSE);
        r[CTRL_FREE_BIT] = st.free_run;
        r[CTRL_IRQ_EN_BIT] = st.irq_en;
        r[CTRL_DMA_EN_BIT] = st.dma_en;
        r[CTRL_PIN_SEL_LSB +: 2] = st.pin_sel;
        r[CTRL_FLAG_BIT] = st.flag;
        r[CTRL_POL_BIT] = st.pol;
        return r;
    endfunction : ctrl_image

    function automatic logic [31:0] psc_image(input state_t st);
        logic [31:0] r;
        r = 32'h00000000;
        r[PSC_VALUE_LSB +: 4] = st.psc_val;
        r[PSC_BYPASS_BIT] = st.bypass;
        r[PSC_CLK_SEL_LSB +: 2] = st.clk_sel;
        return r;
    endfunction : psc_image

    // ==========================================================
    // state

    localparam state_t STATE_RST = '{
        enable: RST_CONTROL[CTRL_ENABLE_BIT],
        mode: MODE_TIME,
        free_run: RST_CONTROL[CTRL_FREE_BIT],
        irq_en: RST_CONTROL[CTRL_IRQ_EN_BIT],
        dma_en: RST_CONTROL[CTRL_DMA_EN_BIT],
        pin_sel: RST_CONTROL[CTRL_PIN_SEL_LSB +: 2],
        pol: RST_CONTROL[CTRL_POL_BIT],
        flag: 1'b0,
        psc_val: RST_PSC_VALUE,
        bypass: RST_BYPASS,
        clk_sel: RST_CLK_SEL,
        compare: RST_COMPARE,
        count: 32'h00000000,
        psc_cnt: 16'h0000,
        filt_cnt: 16'h0000,
        filt_lvl: 1'b0,
        src_prev: 1'b0,
        pin_prev: 1'b0,
        wreq: 1'b1,
        rdata: 32'h00000000,
        irq: 1'b0,
        trig: 1'b0,
        dma: 1'b0
    };

    state_t s_r;
    state_t s_nxt;
    logic [31:0] wimg;
    logic src_lvl;
    logic src_tick;
    logic pin_lvl;
    logic inc;
    logic set_flag;
    logic clr_flag;
    logic wr_fire;
    logic [15:0] filt_lim;

    // ==========================================================
    // next-state logic
    always_comb begin
        s_nxt = s_r;
        wimg = 32'h00000000;
        inc = 1'b0;
        set_flag = 1'b0;
        clr_flag = 1'b0;
        s_nxt.trig = 1'b0;

        // source clocks are plain levels here; a rising edge is one count tick
        src_lvl = src_clk_i[s_r.clk_sel];
        src_tick = src_lvl & ~s_r.src_prev;
        s_nxt.src_prev = src_lvl;

        // polarity folds an active-low input into a rising active edge
        pin_lvl = pulse_in_i[s_r.pin_sel] ^ s_r.pol;
        s_nxt.pin_prev = pin_lvl;

        // code 0 has no filter setting of its own; it behaves as code 1
        filt_lim = (s_r.psc_val == 4'h0) ? low_mask(5'd1) : low_mask({1'b0, s_r.psc_val});

        // tick generation per mode
        if (s_r.mode == MODE_TIME) begin
            if (s_r.bypass) begin
                inc = src_tick;
            end else if (src_tick) begin
                if (s_r.psc_cnt == low_mask({1'b0, s_r.psc_val} + 5'd1)) begin
                    s_nxt.psc_cnt = 16'h0000;
                    inc = 1'b1;
                end else begin
                    s_nxt.psc_cnt = s_r.psc_cnt + 16'h0001;
                end
            end
        end else begin
            if (s_r.bypass) begin
                inc = pin_lvl & ~s_r.pin_prev;
            end else begin
                // filtered level moves only after 2^n differing samples in a row
                if (src_tick) begin
                    if (pin_lvl == s_r.filt_lvl) begin
                        s_nxt.filt_cnt = 16'h0000;
                    end else if (s_r.filt_cnt == filt_lim) begin
                        s_nxt.filt_cnt = 16'h0000;
                        s_nxt.filt_lvl = pin_lvl;
                    end else begin
                        s_nxt.filt_cnt = s_r.filt_cnt + 16'h0001;
                    end
                end
                inc = s_nxt.filt_lvl & ~s_r.filt_lvl;
            end
        end

        // counter core; disabled keeps everything parked at zero
        if (!s_r.enable) begin
            s_nxt.count = 32'h00000000;
            s_nxt.psc_cnt = 16'h0000;
            s_nxt.filt_cnt = 16'h0000;
            s_nxt.filt_lvl = 1'b0;
            s_nxt.flag = 1'b0;
        end else if (inc) begin
            if (s_r.count == s_r.compare) begin
                set_flag = 1'b1;
                s_nxt.trig = 1'b1;
                s_nxt.count = s_r.free_run ? s_r.count + 32'h00000001 : 32'h00000000;
            end else begin
                s_nxt.count = s_r.count + 32'h00000001;
            end
        end

        // bus slave: one wait state, then write commits and read data stands
        wr_fire = avs_write_i & ~s_r.wreq;
        if ((avs_read_i | avs_write_i) & s_r.wreq) begin
            s_nxt.wreq = 1'b0;
        end else begin
            s_nxt.wreq = 1'b1;
        end

        // read data is latched only for reads, so it stands until the next read answer
        if (avs_read_i & s_r.wreq) begin
            unique case (avs_address_i)
                OFS_CONTROL: s_nxt.rdata = ctrl_image(s_r);
                OFS_PRESCALE: s_nxt.rdata = psc_image(s_r);
                OFS_COMPARE: s_nxt.rdata = s_r.compare;
                OFS_COUNTER: s_nxt.rdata = s_r.count;
                default: s_nxt.rdata = 32'h00000000;
            endcase
        end

        if (wr_fire) begin
            unique case (avs_address_i)
                OFS_CONTROL: begin
                    wimg = merge_be(ctrl_image(s_r), avs_writedata_i, avs_byteenable_i);
                    s_nxt.enable = wimg[CTRL_ENABLE_BIT];
                    s_nxt.mode = wimg[CTRL_MODE_BIT] ? MODE_PULSE : MODE_TIME;
                    s_nxt.free_run = wimg[CTRL_FREE_BIT];
                    s_nxt.irq_en = wimg[CTRL_IRQ_EN_BIT];
                    s_nxt.dma_en = wimg[CTRL_DMA_EN_BIT];
                    s_nxt.pin_sel = wimg[CTRL_PIN_SEL_LSB +: 2];
                    s_nxt.pol = wimg[CTRL_POL_BIT];
                    clr_flag = avs_byteenable_i[CTRL_FLAG_BIT / 8] & avs_writedata_i[CTRL_FLAG_BIT];
                end
                OFS_PRESCALE: begin
                    wimg = merge_be(psc_image(s_r), avs_writedata_i, avs_byteenable_i);
                    s_nxt.psc_val = wimg[PSC_VALUE_LSB +: 4];
                    s_nxt.bypass = wimg[PSC_BYPASS_BIT];
                    s_nxt.clk_sel = wimg[PSC_CLK_SEL_LSB +: 2];
                end
                OFS_COMPARE: begin
                    s_nxt.compare = merge_be(s_r.compare, avs_writedata_i, avs_byteenable_i);
                end
                default: begin
                    wimg = 32'h00000000; // counter and holes ignore writes
                end
            endcase
        end

        // flag: a compare event in the clearing cycle still wins
        if (clr_flag) begin
            s_nxt.flag = 1'b0;
        end
        if (set_flag) begin
            s_nxt.flag = 1'b1;
        end

        // request outputs follow the next flag value, so they change in the same cycle as the flag, from flops
        s_nxt.irq = s_nxt.flag & s_nxt.irq_en;
        s_nxt.dma = s_nxt.flag & s_nxt.dma_en;
    end

    // ==========================================================
    // operating notes
    //
    // bus timing
    // - every access costs one wait cycle: the request edge drops waitrequest,
    //   the next edge accepts it and raises waitrequest again
    // - a write commits only at the accepting edge, never at the request edge,
    //   so a master that holds its request as required writes exactly once
    // - back to back accesses therefore take two cycles each; the cost is
    //   small against the slow count rates this block is meant for
    // - read data is captured at the request edge and stands until the next
    //   read answer; writes leave it alone so a late sampler still sees it
    //
    // counting
    // - source clocks and pulse pins are sampled as plain levels; a source
    //   must stay high and low for at least one core cycle each, or its edges
    //   are lost; this is the price of having a single clock in the block
    // - the edge history runs while disabled, so enabling never counts a
    //   level that was already high as a fresh edge, except in filtered pulse mode, where the filter restarts low and counts it
    // - switching mode or bypass while enabled may count one spurious edge;
    //   software should disable, reconfigure and then enable again
    // - the prescaler counts source edges and hands one increment on to the
    //   counter every 2^(n+1) of them
    // - the filter holds its level until the input has differed from it for
    //   2^n source ticks in a row; one matching tick restarts the run
    // - filter code 0 has no setting of its own and acts as code 1
    //
    // compare event
    // - the event is the increment taken while count equals compare, so the
    //   counter shows the compare value for a full count period first
    // - without free running the counter returns to zero on that increment;
    //   with it the counter passes on and wraps only after all ones
    // - without free running, a compare value of zero makes every increment an event
    //
    // flag and requests
    // - the flag is set by the event and cleared by writing one to it, or by
    //   disabling; an event in the clearing cycle wins so none is lost
    // - interrupt and dma requests are levels that follow the flag and their
    //   enables, registered so that every output comes from a flip-flop
    // - the trigger is a single-cycle pulse per event, independent of enables
    //
    // limitations
    // - byte lanes apply to writes only; reads return the whole word
    // - the counter register ignores writes; holes read zero

    // ==========================================================
    // state register
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign avs_readdata_o = s_r.rdata;
    assign avs_waitrequest_o = s_r.wreq;
    assign irq_o = s_r.irq;
    assign trigger_o = s_r.trig;
    assign dma_req_o = s_r.dma;

endmodule : low_power_timer_counter

// file: design/lptc_pkg.sv
package lptc_pkg;

    // ==========================================================
    // register map (byte addresses, one 32-bit word each)
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_PRESCALE = 4'h4;
    localparam logic [3:0] OFS_COMPARE = 4'h8;
    localparam logic [3:0] OFS_COUNTER = 4'hC;

    // ==========================================================
    // control register fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam int CTRL_FREE_BIT = 2;
    localparam int CTRL_IRQ_EN_BIT = 3;
    localparam int CTRL_DMA_EN_BIT = 4;
    localparam int CTRL_PIN_SEL_LSB = 5;
    localparam int CTRL_FLAG_BIT = 7;
    localparam int CTRL_POL_BIT = 8;

    // ==========================================================
    // prescale register fields
    localparam int PSC_VALUE_LSB = 0;
    localparam int PSC_BYPASS_BIT = 4;
    localparam int PSC_CLK_SEL_LSB = 5;

    // ==========================================================
    // reset values
    localparam logic [31:0] RST_CONTROL = 32'h00000000;
    localparam logic [3:0] RST_PSC_VALUE = 4'h0;
    localparam logic RST_BYPASS = 1'b0;
    localparam logic [1:0] RST_CLK_SEL = 2'h0;
    localparam logic [31:0] RST_COMPARE = 32'h00000000;

    typedef enum logic {
        MODE_TIME,
        MODE_PULSE
    } mode_t;

    // whole block state, registered as one word
    typedef struct packed {
        logic enable;
        mode_t mode;
        logic free_run;
        logic irq_en;
        logic dma_en;
        logic [1:0] pin_sel;
        logic pol;
        logic flag;
        logic [3:0] psc_val;
        logic bypass;
        logic [1:0] clk_sel;
        logic [31:0] compare;
        logic [31:0] count;
        logic [15:0] psc_cnt;
        logic [15:0] filt_cnt;
        logic filt_lvl;
        logic src_prev;
        logic pin_prev;
        logic wreq;
        logic [31:0] rdata;
        logic irq;
        logic trig;
        logic dma;
    } state_t;

endpackage : lptc_pkg

// file: verif/ext_pin_model.sv
`timescale 1ns/1ps
// ========================================
// far side: gated source clocks and pulse pins
module ext_pin_model (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [3:0] run_i,
    input wire logic [3:0] level_i,
    output logic [3:0] src_clk_o,
    output logic [3:0] pulse_o
);
    // a source clock only toggles while run, so ticks come in exact numbers
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            src_clk_o <= 4'h0;
        end else begin
            src_clk_o <= src_clk_o ^ run_i;
        end
    end
    assign pulse_o = level_i; // pins are always driven, never released
endmodule : ext_pin_model

// file: verif/low_power_timer_counter_tb_top.sv
`timescale 1ns/1ps
// ========================================
// register level tests of the timer
module low_power_timer_counter_tb_top;
    import lptc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, wt, irq, trig, dma;
    logic [3:0] adr = 4'h0, run = 4'h0, lvl = 4'h0, src, pin;
    logic [31:0] wd = 32'h0, rdat, q, c;
    int miscompares = 0, n_checks = 0, cyc = 0, trigs = 0;
    always #10 clk = ~clk;
    ext_pin_model m (.core_clk_i(clk), .reset_i(rst), .run_i(run), .level_i(lvl), .src_clk_o(src), .pulse_o(pin));
    low_power_timer_counter dut (.core_clk_i(clk), .reset_i(rst), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .src_clk_i(src), .pulse_in_i(pin), .irq_o(irq), .trigger_o(trig), .dma_req_o(dma));
    // trigger pulses are counted here; the cycle ceiling cuts a hang
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (trig === 1'b1) trigs <= trigs + 1;
        if (cyc == 8000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %0t: got %h want %h", $time, s, e);
        end
    endtask : chk
    // request held until waitrequest is seen low; a few idle cycles let outputs settle
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wt !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : bus
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rdc
    task automatic ticks(input int k, input int n);
        run[k] <= 1'b1;
        repeat (2 * n) @(posedge clk);
        run[k] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : ticks
    task automatic pn(input int p, input logic v);
        lvl[p] <= v;
        repeat (3) @(posedge clk);
    endtask : pn
    // field layout mirrors the control and prescale words
    function automatic logic [31:0] ctl(input logic en, md, fr, ie, de, input logic [1:0] ps, input logic pl);
        return {23'h0, pl, 1'b0, ps, de, ie, fr, md, en};
    endfunction : ctl
    function automatic logic [31:0] psc(input logic [3:0] n, input logic by, input logic [1:0] cs);
        return {25'h0, cs, by, n};
    endfunction : psc
    // restart through disable so count, prescaler and filter begin from zero
    task automatic go(input logic [31:0] v);
        bus(1'b1, OFS_CONTROL, v & ~32'h1);
        bus(1'b1, OFS_CONTROL, v);
    endtask : go
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdc(OFS_CONTROL, RST_CONTROL);
        rdc(OFS_COMPARE, RST_COMPARE);
        bus(1'b1, OFS_COUNTER, 32'h55);
        rdc(OFS_COUNTER, 32'h0);
        rdc(4'h1, 32'h0);
        // one-shot compare on source clock 2, source clock 0 must not count
        bus(1'b1, OFS_PRESCALE, psc(4'h0, 1'b1, 2'h2));
        bus(1'b1, OFS_COMPARE, 32'h3);
        c = ctl(1, 0, 0, 1, 1, 2'h0, 0);
        go(c);
        ticks(2, 3);
        ticks(0, 2);
        rdc(OFS_COUNTER, 32'h3);
        ticks(2, 1);
        rdc(OFS_COUNTER, 32'h0);
        rdc(OFS_CONTROL, c | 32'h80);
        chk(32'({irq, dma, 5'(trigs)}), 32'h61);
        bus(1'b1, OFS_CONTROL, c);
        chk(q, c | 32'h80);
        chk(32'(irq), 32'h1);
        bus(1'b1, OFS_CONTROL, c | 32'h80);
        chk(32'({irq, dma}), 32'h0);
        // free running passes the compare value
        bus(1'b1, OFS_COMPARE, 32'h1);
        bus(1'b1, OFS_CONTROL, ctl(1, 0, 1, 0, 0, 2'h0, 0));
        ticks(2, 3);
        rdc(OFS_COUNTER, 32'h3);
        chk(32'(trigs), 32'h2);
        bus(1'b1, OFS_CONTROL, 32'h0);
        rdc(OFS_COUNTER, 32'h0);
        rdc(OFS_CONTROL, 32'h0);
        // prescaler: one edge short of the third count
        bus(1'b1, OFS_COMPARE, 32'h64);
        for (int n = 0; n < 3; n++) begin
            bus(1'b1, OFS_PRESCALE, psc(4'(n), 1'b0, 2'h1));
            go(ctl(1, 0, 0, 0, 0, 2'h0, 0));
            ticks(1, 3 * (2 << n) - 1);
            rdc(OFS_COUNTER, 32'h2);
        end
        // raw pulse counting on every pin and polarity; the neighbour pin is ignored
        bus(1'b1, OFS_PRESCALE, psc(4'h0, 1'b1, 2'h0));
        for (int i = 0; i < 8; i++) begin
            lvl <= {4{i[2]}};
            go(ctl(1, 1, 0, 0, 0, 2'(i), i[2]));
            repeat (2) begin
                pn(i % 4, !i[2]);
                pn(i % 4, i[2]);
                pn((i + 1) % 4, !i[2]);
                pn((i + 1) % 4, i[2]);
            end
            rdc(OFS_COUNTER, 32'h2);
        end
        go(ctl(1, 0, 0, 0, 0, 2'h3, 1));
        pn(3, 0);
        pn(3, 1);
        rdc(OFS_COUNTER, 32'h0);
        // filter of two samples drops a one-tick glitch
        lvl <= 4'h0;
        bus(1'b1, OFS_PRESCALE, psc(4'h1, 1'b0, 2'h3));
        go(ctl(1, 1, 0, 0, 0, 2'h0, 0));
        pn(0, 1);
        ticks(3, 1);
        pn(0, 0);
        ticks(3, 2);
        rdc(OFS_COUNTER, 32'h0);
        pn(0, 1);
        ticks(3, 2);
        rdc(OFS_COUNTER, 32'h1);
        stop_test();
    end
endmodule : low_power_timer_counter_tb_top

// file: verif/lptc_sva.sv
`timescale 1ns/1ps
// ========================================
// bus timing and event output checks
module lptc_sva (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic irq_o,
    input wire logic trigger_o,
    input wire logic dma_req_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    wire logic req = avs_read_i || avs_write_i;
    // one wait cycle per access, then idle again
    bus_answer_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
    bus_release_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("answer too long");
    bus_idle_a: assert property (!req && avs_waitrequest_o |=> avs_waitrequest_o) else $error("stray answer");
    rdata_hold_a: assert property (!$stable(avs_readdata_o) |-> $fell(avs_waitrequest_o) && avs_read_i)
        else $error("read data moved");
    trig_single_a: assert property (trigger_o |=> !trigger_o) else $error("trigger too wide");
    // irq and dma only rise from a compare event or a register write
    irq_cause_a: assert property ($rose(irq_o) |-> ##[0:1] (trigger_o || $past(trigger_o) || $past(avs_write_i)
        || $past(avs_write_i, 2))) else $error("irq without cause");
    dma_cause_a: assert property ($rose(dma_req_o) |-> ##[0:1] (trigger_o || $past(trigger_o) || $past(avs_write_i)
        || $past(avs_write_i, 2))) else $error("dma without cause");
    irq_fall_a: assert property ($fell(irq_o) |-> $past(avs_write_i) || $past(avs_write_i, 2))
        else $error("irq dropped alone");
    cover property (trigger_o);
    cover property ($rose(irq_o));
    cover property ($fell(irq_o));
endmodule : lptc_sva
bind low_power_timer_counter lptc_sva u_sva (.core_clk_i(core_clk_i), .reset_i(reset_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .irq_o(irq_o), .trigger_o(trigger_o), .dma_req_o(dma_req_o));
